// file: hdl/string_store_to_store_engine.sv
// Store-to-store order engine of the secondary operand unit.
// Assumes a single-beat store port: reads answer with rd_valid, writes are taken with wr_ack.
`timescale 1ns/1ps
module string_store_to_store_engine (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Order request from the pipeline
  input wire logic start,
  input wire logic [4:0] order,
  input wire logic [63:0] operand,
  input wire logic [63:0] main_desc_in,
  input wire logic [63:0] aux_desc_in,
  input wire logic short_source_inhibit,
  input wire logic bound_check_inhibit,
  // Main store port
  output logic rd_req,
  output logic [31:0] rd_addr,
  input wire logic rd_valid,
  input wire logic [31:0] rd_data,
  output logic wr_req,
  output logic [31:0] wr_addr,
  output logic [7:0] wr_data,
  input wire logic wr_ack,
  // Results
  output logic busy,
  output logic done,
  output logic [63:0] main_desc,
  output logic [63:0] aux_descriptor,
  output logic [1:0] test_reg,
  output logic boolean_flag,
  output logic short_source_irq,
  output logic bound_check_irq,
  output logic type_size_irq
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [6:0] {
    st_idle = 7'b0000001,
    st_step = 7'b0000010,
    st_rd_src = 7'b0000100,
    st_rd_dst = 7'b0001000,
    st_rd_tab = 7'b0010000,
    st_write = 7'b0100000,
    st_end = 7'b1000000
  } state_t;

  state_t state_r, state_nxt;
  sts_pkg::order_t ord_r, ord_nxt;
  logic [63:0] opnd_r, opnd_nxt;
  logic [63:0] md_r, md_nxt;
  logic [63:0] xd_r, xd_nxt;
  logic [7:0] sbyte_r, sbyte_nxt;
  logic [7:0] dbyte_r, dbyte_nxt;
  logic [31:0] waddr_r, waddr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic [1:0] test_r, test_nxt;
  logic bn_r, bn_nxt;
  logic sss_r, sss_nxt;
  logic bch_r, bch_nxt;
  logic its_r, its_nxt;
  logic done_r, done_nxt;

  // ------------------------------------------------------------
  // Field views
  // ------------------------------------------------------------
  logic [7:0] mask;
  logic [7:0] filler;
  logic [3:0] fn;
  logic [23:0] main_bound, aux_bound;
  logic [31:0] main_origin, aux_origin;
  logic src_str, byte_src;
  logic [7:0] src_m, dst_m, logic_out, move_out;
  logic aux_ok, main_ok, main_word_ok;

  function automatic logic [63:0] advance(input logic [63:0] d, input logic [31:0] n);
    advance = {d[63:56], d[55:32] - n[23:0], d[31:0] + n};
  endfunction : advance

  always_comb begin
    mask = opnd_r[sts_pkg::MASK_LSB +: 8];
    filler = opnd_r[sts_pkg::FILL_LSB +: 8];
    fn = opnd_r[sts_pkg::FN_LSB +: 4];
    main_bound = md_r[sts_pkg::DBOUND_LSB +: 24];
    aux_bound = xd_r[sts_pkg::DBOUND_LSB +: 24];
    main_origin = md_r[sts_pkg::DORIG_LSB +: 32];
    aux_origin = xd_r[sts_pkg::DORIG_LSB +: 32];
    src_str = (ord_r <= sts_pkg::str_logic_combine);
    byte_src = (ord_r >= sts_pkg::byte_move_one) && (ord_r <= sts_pkg::byte_logic_combine);
  end

  byte_alu u_alu (
    .src(sbyte_r),
    .dst(dbyte_r),
    .mask(mask),
    .fn(fn),
    .src_m(src_m),
    .dst_m(dst_m),
    .logic_out(logic_out),
    .move_out(move_out)
  );

  desc_check u_chk_aux (
    .desc(aux_desc_in),
    .byte_str_ok(aux_ok),
    .word_vec_ok()
  );

  desc_check u_chk_main (
    .desc(main_desc_in),
    .byte_str_ok(main_ok),
    .word_vec_ok(main_word_ok)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    ord_nxt = ord_r;
    opnd_nxt = opnd_r;
    md_nxt = md_r;
    xd_nxt = xd_r;
    sbyte_nxt = sbyte_r;
    dbyte_nxt = dbyte_r;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    test_nxt = test_r;
    bn_nxt = bn_r;
    sss_nxt = 1'b0;
    bch_nxt = 1'b0;
    its_nxt = 1'b0;
    done_nxt = 1'b0;
    unique case (state_r)
      st_idle: begin
        if (start) begin
          ord_nxt = sts_pkg::order_t'(order);
          opnd_nxt = operand;
          md_nxt = main_desc_in;
          xd_nxt = aux_desc_in;
          state_nxt = st_step;
          if (order <= sts_pkg::str_logic_combine) begin
            // source and destination checked; always raised
            if (!aux_ok || !main_ok) begin
              its_nxt = 1'b1;
              state_nxt = st_end;
            end
          end else if (order <= sts_pkg::byte_logic_combine) begin
            if (!main_ok) begin
              its_nxt = 1'b1;
              state_nxt = st_end;
            end
          end else if (order <= sts_pkg::table_check) begin
            if (!aux_ok) begin
              its_nxt = 1'b1;
              state_nxt = st_end;
            end
          end else if (order == sts_pkg::table_lookup) begin
            if (!main_word_ok) begin
              its_nxt = 1'b1;
              state_nxt = st_end;
            end
          end else if (order == sts_pkg::subscript_first) begin
            // aux takes dope descriptor, main cleared
            xd_nxt = operand;
            md_nxt = '0;
            state_nxt = st_end;
          end else begin
            state_nxt = st_end;
          end
        end
      end
      st_step: begin
        if (ord_r == sts_pkg::table_translate || ord_r == sts_pkg::table_check) begin
          if (aux_bound == '0) begin
            if (ord_r == sts_pkg::table_check) begin
              bn_nxt = 1'b1;
            end
            state_nxt = st_end;
          end else begin
            state_nxt = st_rd_src;
          end
        end else if (main_bound == '0) begin
          if (ord_r == sts_pkg::str_move_one || ord_r == sts_pkg::byte_move_one) begin
            bch_nxt = !bound_check_inhibit;
          end
          if (ord_r == sts_pkg::str_compare || ord_r == sts_pkg::byte_scan_unequal) begin
            test_nxt = sts_pkg::test_equal;
          end
          if (ord_r == sts_pkg::byte_scan_equal) begin
            test_nxt = sts_pkg::test_less;
          end
          if (ord_r == sts_pkg::table_lookup) begin
            test_nxt = sts_pkg::test_greater;
          end
          state_nxt = st_end;
        end else if (src_str && aux_bound == '0 &&
                     (ord_r == sts_pkg::str_move_full || ord_r == sts_pkg::str_logic_combine)) begin
          sss_nxt = !short_source_inhibit;
          state_nxt = st_end;
        end else if (src_str && aux_bound != '0) begin
          state_nxt = st_rd_src;
        end else begin
          // filler when source empty; operand byte
          sbyte_nxt = byte_src ? opnd_r[7:0] : filler;
          state_nxt = st_rd_dst;
        end
      end
      st_rd_src: begin
        if (rd_valid) begin
          sbyte_nxt = rd_data[7:0];
          state_nxt = (src_str) ? st_rd_dst : st_rd_tab;
        end
      end
      st_rd_tab: begin
        if (rd_valid) begin
          if (ord_r == sts_pkg::table_translate) begin
            waddr_nxt = aux_origin;
            wdata_nxt = ({rd_data[7:0]} & ~mask) | (sbyte_r & mask);
            state_nxt = st_write;
          end else if (rd_data[0]) begin
            bn_nxt = 1'b0;
            state_nxt = st_end;
          end else begin
            xd_nxt = advance(xd_r, sts_pkg::ONE_STEP);
            state_nxt = st_step;
          end
        end
      end
      st_rd_dst: begin
        if (rd_valid) begin
          dbyte_nxt = rd_data[7:0];
          state_nxt = st_write;
          waddr_nxt = main_origin;
          if (ord_r == sts_pkg::table_lookup) begin
            // mask from aux origin; match stops at element
            if ((rd_data & ~aux_origin) == (opnd_r[31:0] & ~aux_origin)) begin
              test_nxt = sts_pkg::test_equal;
              state_nxt = st_end;
            end else begin
              md_nxt = advance(md_r, sts_pkg::WORD_BYTES);
              state_nxt = st_step;
            end
          end
        end
      end
      st_write: begin
        unique case (ord_r)
          sts_pkg::str_compare, sts_pkg::byte_scan_unequal: begin
            if (src_m != dst_m) begin
              test_nxt = (src_m > dst_m) ? sts_pkg::test_greater : sts_pkg::test_less;
              state_nxt = st_end;
            end else begin
              md_nxt = advance(md_r, sts_pkg::ONE_STEP);
              if (src_str && aux_bound != '0) begin
                xd_nxt = advance(xd_r, sts_pkg::ONE_STEP);
              end
              state_nxt = st_step;
            end
          end
          sts_pkg::byte_scan_equal: begin
            if (src_m == dst_m) begin
              test_nxt = sts_pkg::test_equal;
              state_nxt = st_end;
            end else begin
              md_nxt = advance(md_r, sts_pkg::ONE_STEP);
              state_nxt = st_step;
            end
          end
          default: begin
            if (wr_ack) begin
              if (ord_r == sts_pkg::table_translate) begin
                xd_nxt = advance(xd_r, sts_pkg::ONE_STEP);
              end else begin
                md_nxt = advance(md_r, sts_pkg::ONE_STEP);
                if (src_str && aux_bound != '0) begin
                  xd_nxt = advance(xd_r, sts_pkg::ONE_STEP);
                end
              end
              if (ord_r == sts_pkg::str_move_one || ord_r == sts_pkg::byte_move_one) begin
                state_nxt = st_end;
              end else begin
                state_nxt = st_step;
              end
            end
          end
        endcase
      end
      st_end: begin
        done_nxt = 1'b1;
        state_nxt = st_idle;
      end
      default: begin
        state_nxt = st_idle;
      end
    endcase
  end

  // Write data: combine, translated byte for table_translate, else masked move
  logic [7:0] wbyte;
  always_comb begin
    if (ord_r == sts_pkg::str_logic_combine || ord_r == sts_pkg::byte_logic_combine) begin
      wbyte = logic_out;
    end else if (ord_r == sts_pkg::table_translate) begin
      wbyte = wdata_r;
    end else begin
      wbyte = move_out;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= st_idle;
      ord_r <= sts_pkg::str_move_one;
      opnd_r <= '0;
      md_r <= '0;
      xd_r <= '0;
      sbyte_r <= '0;
      dbyte_r <= '0;
      waddr_r <= '0;
      wdata_r <= '0;
      test_r <= sts_pkg::TEST_RESET;
      bn_r <= 1'b0;
      sss_r <= 1'b0;
      bch_r <= 1'b0;
      its_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ord_r <= ord_nxt;
      opnd_r <= opnd_nxt;
      md_r <= md_nxt;
      xd_r <= xd_nxt;
      sbyte_r <= sbyte_nxt;
      dbyte_r <= dbyte_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      test_r <= test_nxt;
      bn_r <= bn_nxt;
      sss_r <= sss_nxt;
      bch_r <= bch_nxt;
      its_r <= its_nxt;
      done_r <= done_nxt;
    end
  end

  // Store port: address chosen from state, so requests follow state flops
  always_comb begin
    rd_req = (state_r == st_rd_src) || (state_r == st_rd_dst) || (state_r == st_rd_tab);
    if (state_r == st_rd_src) begin
      rd_addr = aux_origin;
    end else if (state_r == st_rd_tab) begin
      rd_addr = main_origin + {24'h0, src_m};
    end else begin
      rd_addr = main_origin;
    end
    wr_req = (state_r == st_write) && (ord_r != sts_pkg::str_compare) &&
      (ord_r != sts_pkg::byte_scan_unequal) && (ord_r != sts_pkg::byte_scan_equal);
    wr_addr = waddr_r;
    wr_data = wbyte;
    busy = (state_r != st_idle);
    done = done_r;
    main_desc = md_r;
    aux_descriptor = xd_r;
    test_reg = test_r;
    boolean_flag = bn_r;
    short_source_irq = sss_r;
    bound_check_irq = bch_r;
    type_size_irq = its_r;
  end

endmodule : string_store_to_store_engine

// file: hdl/sts_pkg.sv
// Package for the store-to-store engine: order codes, operand fields, descriptor fields.
// Assumes a 64-bit operand with bit 0 as the most significant bit, as the order code numbers it.
package sts_pkg;

  // ------------------------------------------------------------
  // Order codes
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    str_move_one = 5'h00,
    str_move_full = 5'h01,
    str_move_fill = 5'h02,
    str_compare = 5'h03,
    str_logic_combine = 5'h04,
    byte_move_one = 5'h05,
    byte_fill_full = 5'h06,
    byte_scan_equal = 5'h07,
    byte_scan_unequal = 5'h08,
    byte_logic_combine = 5'h09,
    table_translate = 5'h0a,
    table_check = 5'h0b,
    table_lookup = 5'h0c,
    subscript_first = 5'h0d,
    subscript_next = 5'h0e
  } order_t;

  // Test register outcome codes
  typedef enum logic [1:0] {
    test_equal = 2'h0,
    test_greater = 2'h1,
    test_less = 2'h2
  } test_t;

  // ------------------------------------------------------------
  // Field positions (little-endian index = 63 - printed digit)
  // ------------------------------------------------------------
  localparam int MASK_LSB = 8;
  localparam int FILL_LSB = 0;
  localparam int FN_LSB = 16;
  localparam int LOOKUP_LSB = 0;

  // Descriptor: type [63:56], bound [55:32], origin [31:0]
  localparam int DTYPE_LSB = 56;
  localparam int DBOUND_LSB = 32;
  localparam int DORIG_LSB = 0;
  // Element size field within the type byte
  localparam int SIZE_LSB = 59;

  localparam logic [2:0] SIZE_BYTE = 3'h3;
  localparam logic [2:0] SIZE_WORD = 3'h5;
  localparam logic [1:0] TYPE_MAX_BYTESTR = 2'h2;
  localparam logic [31:0] WORD_BYTES = 32'h4;
  localparam logic [31:0] TRIPLE_BYTES = 32'hc;

  // Byte step and reset value of the test register
  localparam logic [31:0] ONE_STEP = 32'h1;
  localparam logic [1:0] TEST_RESET = 2'h0;

endpackage : sts_pkg

// file: hdl/byte_alu.sv
// Masked byte arithmetic for the store-to-store engine: mask, merge and logic combine.
// Assumes purely combinational use by the engine on the current byte pair.
`timescale 1ns/1ps
module byte_alu (
  // Operands
  input wire logic [7:0] src,
  input wire logic [7:0] dst,
  input wire logic [7:0] mask,
  input wire logic [3:0] fn,
  // Results
  output logic [7:0] src_m,
  output logic [7:0] dst_m,
  output logic [7:0] logic_out,
  output logic [7:0] move_out
);
  always_comb begin
    src_m = src & ~mask;
    dst_m = dst & ~mask;
    for (int i = 0; i < 8; i++) begin
      logic_out[i] = (dst[i] & mask[i]) |
        (~mask[i] & fn[3 - {src_m[i], dst_m[i]}]);
    end
    move_out = (dst & mask) | (src & ~mask);
  end
endmodule : byte_alu

// file: hdl/desc_check.sv
// Descriptor type and element-size check for string and table operands.
// Assumes the descriptor is the 64-bit register image given to the engine with the order.
`timescale 1ns/1ps
module desc_check (
  // Descriptor
  input wire logic [63:0] desc,
  // Results
  output logic byte_str_ok,
  output logic word_vec_ok
);
  logic [7:0] dtype;
  always_comb begin
    dtype = desc[sts_pkg::DTYPE_LSB +: 8];
    // types 0 to 2, byte element
    byte_str_ok = (dtype[7:6] <= sts_pkg::TYPE_MAX_BYTESTR) &&
      (dtype[5:3] == sts_pkg::SIZE_BYTE);
    // type 0 or 2, 32-bit element
    word_vec_ok = ((dtype[7:6] == 2'h0) || (dtype[7:6] == 2'h2)) &&
      (dtype[5:3] == sts_pkg::SIZE_WORD);
  end
endmodule : desc_check

// file: verification/sts_engine_props.sv
// Checker for the store-to-store engine: store handshakes and outcome timing at the ports.
// Assumes it is bound into the engine and sees only its ports.
`timescale 1ns/1ps
module sts_engine_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Order request
  input wire logic start,
  input wire logic short_source_inhibit,
  input wire logic bound_check_inhibit,
  // Store port
  input wire logic rd_req,
  input wire logic [31:0] rd_addr,
  input wire logic rd_valid,
  input wire logic wr_req,
  input wire logic [31:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_ack,
  // Results
  input wire logic busy,
  input wire logic done,
  input wire logic short_source_irq,
  input wire logic bound_check_irq,
  input wire logic type_size_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Last accepted write of the current order
  // ----------------------------------------
  logic seen_r;
  logic seen_nxt;
  logic [31:0] last_r;
  logic [31:0] last_nxt;
  always_comb begin
    seen_nxt = seen_r;
    last_nxt = last_r;
    if (start && !busy) begin
      seen_nxt = 1'b0;
    end else if (wr_req && wr_ack) begin
      seen_nxt = 1'b1;
      last_nxt = wr_addr;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_r <= 1'b0;
      last_r <= 32'h0;
    end else begin
      seen_r <= seen_nxt;
      last_r <= last_nxt;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_done_pulse: assert property (done |=> !done)
    else $error("done held longer than one cycle");
  a_order_ends: assert property (start && !busy |=> busy ##[0:1000] done)
    else $error("order taken but not finished in time");
  a_idle_quiet: assert property (!busy |-> !rd_req && !wr_req)
    else $error("store request while idle");
  a_ss_done: assert property (short_source_irq |=> done)
    else $error("short source not followed by done");
  a_bc_done: assert property (bound_check_irq |=> done)
    else $error("bound check not followed by done");
  a_ts_done: assert property (type_size_irq |=> done)
    else $error("type error not followed by done");
  a_ss_inhibit: assert property (short_source_inhibit |-> !short_source_irq)
    else $error("short source raised while inhibited");
  a_bc_inhibit: assert property (bound_check_inhibit |-> !bound_check_irq)
    else $error("bound check raised while inhibited");
  a_rd_held: assert property (rd_req && !rd_valid |=> rd_req && $stable(rd_addr))
    else $error("read request dropped or moved before answer");
  a_wr_held: assert property (wr_req && !wr_ack |=> wr_req && $stable({wr_addr, wr_data}))
    else $error("write request dropped or moved before ack");
  a_wr_ascend: assert property (wr_req && wr_ack && seen_r |-> wr_addr == last_r + 32'h1)
    else $error("writes not in ascending address order");
  cover property (short_source_irq);
  cover property (type_size_irq);
  cover property (done ##1 start);
endmodule : sts_engine_props

// file: verification/store_model.sv
// Main store model: 256 bytes, each request answered at once or after a three-cycle wait.
// Assumes the engine holds a request until answered; only the low address byte decodes.
`timescale 1ns/1ps
module store_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Wait choice
  input wire logic slow,
  // Store port
  input wire logic rd_req,
  input wire logic [31:0] rd_addr,
  output logic rd_valid,
  output logic [31:0] rd_data,
  input wire logic wr_req,
  input wire logic [31:0] wr_addr,
  input wire logic [7:0] wr_data,
  output logic wr_ack
);
  logic [7:0] mem [256];
  logic [1:0] wait_r;
  logic [31:0] junk_r;
  // Answers exist only while the request stands
  assign rd_valid = rd_req && (!slow || wait_r == 2'h3);
  assign wr_ack = wr_req && (!slow || wait_r == 2'h3);
  // Outside an answer the data churns, so a stale byte is never mistaken for a good one
  assign rd_data = rd_valid ? {24'h0, mem[rd_addr[7:0]]} : junk_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 2'h0;
      junk_r <= 32'h5a5a5a5a;
    end else begin
      junk_r <= ~junk_r;
      wait_r <= ((rd_req || wr_req) && !(rd_valid || wr_ack)) ? wait_r + 2'h1 : 2'h0;
      if (wr_ack) begin
        mem[wr_addr[7:0]] <= wr_data;
      end
    end
  end
endmodule : store_model

// file: verification/string_store_to_store_engine_tb.sv
// Testbench for the store-to-store engine: runs orders and checks each outcome off a queue.
// Assumes store_model as main store and the checker bound at the foot of this file.
`timescale 1ns/1ps
module string_store_to_store_engine_tb;
  typedef struct {logic [1:0] t; logic [1:0] bn; logic [2:0] irq; logic [23:0] db;
    logic [7:0] a; logic [7:0] b; logic [23:0] xb;} note_t;
  localparam logic [1:0] X = 2'h3;
  localparam logic [63:0] TY = 64'hc000000000000000;
  localparam logic [63:0] SZ = 64'h3000000000000000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic [4:0] order = 5'h00;
  logic [63:0] operand = 64'h0;
  logic [63:0] main_desc_in = 64'h0;
  logic [63:0] aux_desc_in = 64'h0;
  logic short_source_inhibit = 1'b0;
  logic bound_check_inhibit = 1'b0;
  logic slow = 1'b0;
  logic rd_req, rd_valid, wr_req, wr_ack, busy, done, boolean_flag;
  logic short_source_irq, bound_check_irq, type_size_irq;
  logic [31:0] rd_addr, rd_data, wr_addr;
  logic [7:0] wr_data, r, s;
  logic [63:0] main_desc, aux_descriptor;
  logic [1:0] test_reg;
  logic [2:0] seen;
  logic [23:0] xb = 24'h0;
  logic [16:0] rnd = 17'h13e0b;
  note_t q[$];
  note_t n;
  int fail_count = 0;
  int n_compared = 0;
  string_store_to_store_engine i_dut (.*);
  store_model i_mem (.*);
  always #20 clk = ~clk;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [16:0] lfsr(input logic [16:0] x);
    return {x[15:0], x[16] ^ x[13]};
  endfunction : lfsr
  function automatic logic [63:0] op(input logic [3:0] f, input logic [7:0] m,
      input logic [7:0] b);
    return {44'h0, f, m, b};
  endfunction : op
  function automatic logic [63:0] d(input logic [7:0] o, input logic [23:0] b);
    return {8'h18, b, 24'h0, o};
  endfunction : d
  task automatic put(input logic [7:0] a, input logic [7:0] b);
    i_mem.mem[a] = b;
  endtask : put
  task automatic conclude();
    if (fail_count == 0 && n_compared > 0 && q.size() == 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic run(input sts_pkg::order_t o, input logic [63:0] opd, input logic [63:0] md,
      input logic [63:0] ad, input logic [1:0] inh, input logic [1:0] t, input logic [1:0] bn,
      input logic [2:0] irq, input logic [23:0] db, input logic [7:0] a, input logic [7:0] b);
    int k;
    @(posedge clk);
    #1;
    order = o;
    operand = opd;
    main_desc_in = md;
    aux_desc_in = ad;
    {short_source_inhibit, bound_check_inhibit} = inh;
    rnd = lfsr(rnd);
    slow = rnd[0];
    start = 1'b1;
    q.push_back('{t, bn, irq, db, a, b, xb});
    @(posedge clk);
    #1;
    start = 1'b0;
    for (k = 0; k < 3000 && done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 3000) begin
      fail_count++;
      $display("BAD %0t order never finished", $time);
      conclude();
    end
  endtask : run
  // ----------------------------------------
  // Outcome watcher
  // ----------------------------------------
  always @(posedge clk) begin
    if (start) seen <= 3'h0;
    else seen <= seen | {short_source_irq, bound_check_irq, type_size_irq};
    if (done === 1'b1) begin
      n = q.pop_front();
      n_compared++;
      if ((n.t != X && test_reg !== n.t) || (n.bn != X && boolean_flag !== n.bn[0])
          || seen !== n.irq || main_desc[55:32] !== n.db || aux_descriptor[55:32] !== n.xb
          || (n.a != 8'h0 && i_mem.mem[n.a] !== n.b)) begin
        fail_count++;
        $display("BAD %0t order outcome differs", $time);
      end
    end
  end
  // ----------------------------------------
  // Orders
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rnd = lfsr(rnd);
    r = rnd[8:1];
    rnd = lfsr(rnd);
    s = rnd[8:1];
    put(8'h10, r);
    run(sts_pkg::str_move_fill, op(4'h0, 8'h00, 8'h5a), d(8'h20, 24'h2), d(8'h10, 24'h1),
      2'h0, X, X, 3'h0, 24'h0, 8'h21, 8'h5a);
    run(sts_pkg::str_move_full, op(4'h0, 8'h00, 8'h00), d(8'h20, 24'h3), d(8'h10, 24'h1),
      2'h0, X, X, 3'h4, 24'h2, 8'h20, r);
    run(sts_pkg::str_move_full, op(4'h0, 8'h00, 8'h00), d(8'h20, 24'h3), d(8'h10, 24'h1),
      2'h2, X, X, 3'h0, 24'h2, 8'h20, r);
    xb = 24'h1;
    run(sts_pkg::str_move_one, op(4'h0, 8'h00, 8'h00), d(8'h20, 24'h0), d(8'h10, 24'h1),
      2'h0, X, X, 3'h2, 24'h0, 8'h00, 8'h00);
    xb = 24'h0;
    run(sts_pkg::str_move_one, op(4'h0, 8'h00, 8'h3c), d(8'h24, 24'h1), d(8'h10, 24'h0),
      2'h1, X, X, 3'h0, 24'h0, 8'h24, 8'h3c);
    xb = 24'h1;
    run(sts_pkg::str_compare, op(4'h0, 8'h00, 8'h00), d(8'h20, 24'h2), d(8'h10, 24'h1) | TY,
      2'h0, X, X, 3'h1, 24'h2, 8'h00, 8'h00);
    put(8'h10, 8'h80);
    put(8'h20, 8'h01);
    run(sts_pkg::str_compare, op(4'h0, 8'h00, 8'h00), d(8'h20, 24'h1), d(8'h10, 24'h1),
      2'h0, sts_pkg::test_greater, X, 3'h0, 24'h1, 8'h00, 8'h00);
    xb = 24'h0;
    run(sts_pkg::str_compare, op(4'h0, 8'h81, 8'h00), d(8'h20, 24'h1), d(8'h10, 24'h1),
      2'h0, sts_pkg::test_equal, X, 3'h0, 24'h0, 8'h00, 8'h00);
    put(8'h20, 8'h11);
    put(8'h21, 8'h77);
    run(sts_pkg::byte_scan_equal, op(4'h0, 8'h00, 8'h77), d(8'h20, 24'h4), 64'h0,
      2'h0, sts_pkg::test_equal, X, 3'h0, 24'h3, 8'h00, 8'h00);
    run(sts_pkg::byte_scan_unequal, op(4'h0, 8'h00, 8'h11), d(8'h20, 24'h4), 64'h0,
      2'h0, sts_pkg::test_less, X, 3'h0, 24'h3, 8'h00, 8'h00);
    run(sts_pkg::byte_fill_full, op(4'h0, 8'hf0, 8'h12), d(8'h20, 24'h2), 64'h0,
      2'h0, X, X, 3'h0, 24'h0, 8'h21, 8'h72);
    run(sts_pkg::byte_move_one, op(4'h0, 8'h00, r), d(8'h22, 24'h2), 64'h0,
      2'h0, X, X, 3'h0, 24'h1, 8'h22, r);
    run(sts_pkg::byte_logic_combine, op(4'h6, 8'h00, s), d(8'h21, 24'h1), 64'h0,
      2'h0, X, X, 3'h0, 24'h0, 8'h21, 8'h72 ^ s);
    run(sts_pkg::str_logic_combine, op(4'h8, 8'h00, 8'h00), d(8'h20, 24'h1), d(8'h10, 24'h1),
      2'h0, X, X, 3'h0, 24'h0, 8'h20, 8'h6d);
    put(8'h40, 8'h03);
    put(8'h83, r);
    run(sts_pkg::table_translate, op(4'h0, 8'h00, 8'h00), d(8'h80, 24'h100), d(8'h40, 24'h1),
      2'h0, X, X, 3'h0, 24'h100, 8'h40, r);
    put(8'h41, 8'h02);
    put(8'h42, 8'h05);
    put(8'h82, 8'hfe);
    put(8'h85, 8'h01);
    xb = 24'h1;
    run(sts_pkg::table_check, op(4'h0, 8'h00, 8'h00), d(8'h80, 24'h100), d(8'h41, 24'h2),
      2'h0, X, 2'h0, 3'h0, 24'h100, 8'h00, 8'h00);
    put(8'h85, 8'h00);
    xb = 24'h0;
    run(sts_pkg::table_check, op(4'h0, 8'h00, 8'h00), d(8'h80, 24'h100), d(8'h41, 24'h2),
      2'h0, X, 2'h1, 3'h0, 24'h100, 8'h00, 8'h00);
    run(sts_pkg::table_lookup, op(4'h0, 8'h00, 8'h00), d(8'h80, 24'h0) ^ SZ, d(8'h10, 24'h0),
      2'h0, sts_pkg::test_greater, X, 3'h0, 24'h0, 8'h00, 8'h00);
    put(8'h60, 8'h11);
    put(8'h64, 8'h44);
    run(sts_pkg::table_lookup, op(4'h0, 8'h00, 8'h4b), d(8'h60, 24'h8) ^ SZ, d(8'h0f, 24'h0),
      2'h0, sts_pkg::test_equal, X, 3'h0, 24'h4, 8'h00, 8'h00);
    xb = 24'h6;
    run(sts_pkg::subscript_first, d(8'h50, 24'h6) ^ SZ, d(8'h20, 24'h2), 64'h0,
      2'h0, X, X, 3'h0, 24'h0, 8'h00, 8'h00);
    @(posedge clk);
    #1;
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    conclude();
  end
endmodule : string_store_to_store_engine_tb
bind string_store_to_store_engine sts_engine_props i_props (.*);
